// ### design/lfmdp_map.vh
// constants for the lane frame marker data port
// assumes inclusion by bare name from the design files only
`ifndef LFMDP_MAP_VH
`define LFMDP_MAP_VH

// widths of one lane word, its markers and the position counters
`define LFMDP_LANE_BITS      32
`define LFMDP_BYTE_BITS      8
`define LFMDP_MARK_BITS      4
`define LFMDP_POS_BITS       8
`define LFMDP_KPOS_BITS      5

// subclass code that needs the system reference
`define LFMDP_SUBCLASS_SYSREF 2'h1

// field positions of the walk function result
`define LFMDP_WALK_SOF_LSB   0
`define LFMDP_WALK_EOF_LSB   4
`define LFMDP_WALK_SOM_LSB   8
`define LFMDP_WALK_F_LSB     12
`define LFMDP_WALK_K_LSB     20
`define LFMDP_WALK_BITS      25

// reset values
`define LFMDP_POS_RST        8'h00
`define LFMDP_KPOS_RST       5'h00
`define LFMDP_MARK_RST       4'h0

`endif

// ### design/lfmdp_buf2.v
// two-entry buffer with valid and ready on both sides
// assumes one clock and a synchronous active-low reset
module lfmdp_buf2 #(
    parameter W = 40
) (
    input  wire         clk,
    input  wire         resetn,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:1];    // two storage words
    reg         wr_ptr_reg;   // next slot to fill
    reg         rd_ptr_reg;   // slot at the head
    reg [1:0]   count_reg;    // words held, 0..2
    reg         ready_reg;    // not full, kept as a flop

    wire push = in_valid & ready_reg;
    wire pop  = (count_reg != 2'h0) & out_ready;

    assign in_ready  = ready_reg;
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem[rd_ptr_reg];

    // storage has no reset; only the pointers, count and ready flag need one
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointer and fill bookkeeping
    always @(posedge clk) begin
        if (!resetn) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
            ready_reg  <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            // full only when a push lands without a pop on one word
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
                ready_reg <= (count_reg == 2'h0);
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
                ready_reg <= 1'b1;
            end
        end
    end
endmodule // lfmdp_buf2

// ### design/lfmdp_top.v
// frame and multiframe marker logic for the transmit data port, frame marker logic for the receive data port
// assumes one core clock; sysref and tx sync come from pins,
// lane words come from deskewed lane logic on the same clock
`include "lfmdp_map.vh"

// Operation
// - tx multiframe start marker, frame marker code
// - subclass 1 requires sysref before transmitting
// - markers four bits, one per byte
// - one marker shared by all lanes
// - receive outputs all on core clock
// - one active-low receive stream reset
// - earliest octet in least significant byte
// - lane N at bits (N+1)*32-1:N*32
// - valid asserted while data bus valid
// - rx frame start uses same code
// - rx frame start one cycle early
// - first valid byte at position zero
// - rx frame end marker, same code
// - bit i marks byte i
// - several boundaries set several bits
// - rx sync low until comma aligned
module lfmdp_top #(
    parameter LANES = 4
) (
    input  wire                  clk,
    input  wire                  resetn,
    input  wire [1:0]            cfg_subclass,
    input  wire [7:0]            cfg_octets_per_frame_m1,
    input  wire [4:0]            cfg_frames_per_multiframe_m1,
    input  wire                  sysref,
    input  wire                  tx_sync_n,
    output wire                  tx_tready,
    output wire [3:0]            tx_frame_begin_marker,
    output wire [3:0]            tx_multiframe_begin_marker,
    input  wire [32*LANES-1:0]   lane_data,
    input  wire                  lane_valid,
    input  wire                  lane_aligned,
    output wire                  lane_ready,
    output wire                  rx_aresetn,
    output wire [32*LANES-1:0]   rx_tdata,
    output wire                  rx_tvalid,
    input  wire                  rx_tready,
    output wire [3:0]            rx_frame_begin_marker,
    output wire [3:0]            rx_frame_finish_marker,
    output wire                  rx_sync_n
);
    localparam DW = `LFMDP_LANE_BITS * LANES;        // data bus width
    localparam BW = DW + 2 * `LFMDP_MARK_BITS;       // buffer word width

    // walks four bytes of one word through the frame and multiframe
    // counters; bit i of each marker describes byte i of every lane
    function [`LFMDP_WALK_BITS-1:0] lfmdp_walk;
        input [7:0] fpos;
        input [4:0] kpos;
        input [7:0] fm1;
        input [4:0] km1;
        reg   [7:0] f;
        reg   [4:0] k;
        reg   [3:0] sof;
        reg   [3:0] eof;
        reg   [3:0] som;
        integer     i;
        begin
            f   = fpos;
            k   = kpos;
            sof = `LFMDP_MARK_RST;
            eof = `LFMDP_MARK_RST;
            som = `LFMDP_MARK_RST;
            for (i = 0; i < `LFMDP_MARK_BITS; i = i + 1) begin
                sof[i] = (f == 8'h00);
                som[i] = (f == 8'h00) && (k == 5'h00);
                eof[i] = (f == fm1);
                // a one-octet frame sets every frame begin and finish bit in one word
                if (f == fm1) begin
                    f = 8'h00;
                    k = (k == km1) ? 5'h00 : k + 5'h01;
                end else begin
                    f = f + 8'h01;
                end
            end
            lfmdp_walk = {k, f, som, eof, sof};
        end
    endfunction

    // pin synchronisers
    reg sysref_m_reg;      // first stage, read only by the second
    reg sysref_s_reg;      // synchronised sysref
    reg sysref_d_reg;      // previous value for edge detection
    reg sync_m_reg;        // first stage of tx sync
    reg sync_s_reg;        // synchronised tx sync, high = go

    // two flops on each pin before any logic reads it
    always @(posedge clk) begin
        if (!resetn) begin
            sysref_m_reg <= 1'b0;
            sysref_s_reg <= 1'b0;
            sysref_d_reg <= 1'b0;
            sync_m_reg   <= 1'b0;
            sync_s_reg   <= 1'b0;
        end else begin
            sysref_m_reg <= sysref;
            sysref_s_reg <= sysref_m_reg;
            sysref_d_reg <= sysref_s_reg;
            sync_m_reg   <= tx_sync_n;
            sync_s_reg   <= sync_m_reg;
        end
    end

    // in subclass 1 a single sysref edge realigns the tx counters; it is not a clock
    wire sysref_rise = sysref_s_reg & ~sysref_d_reg;
    wire subclass_1  = (cfg_subclass == `LFMDP_SUBCLASS_SYSREF);

    // transmit markers
    reg       tx_seen_reg;     // a sysref edge has arrived
    reg [7:0] tx_fpos_reg;     // octet within frame at next word
    reg [4:0] tx_kpos_reg;     // frame within multiframe
    reg [3:0] tx_sof_reg;      // frame begin marker
    reg [3:0] tx_som_reg;      // multiframe begin marker
    reg       tx_live_reg;     // markers describe the next word
    reg       tx_ready_reg;    // accepts a word, one cycle after live

    // in subclass 1 nothing is sent until sysref has been seen
    wire tx_go = sync_s_reg &
                 (~subclass_1 | tx_seen_reg | sysref_rise);
    // a sysref edge in subclass 1 or a fresh start puts the next word at byte 0
    wire tx_restart = (subclass_1 & sysref_rise) | ~tx_live_reg;
    wire [7:0] tx_f_in = tx_restart ? `LFMDP_POS_RST : tx_fpos_reg;
    wire [4:0] tx_k_in = tx_restart ? `LFMDP_KPOS_RST : tx_kpos_reg;
    wire [`LFMDP_WALK_BITS-1:0] tx_walk =
        lfmdp_walk(tx_f_in, tx_k_in, cfg_octets_per_frame_m1,
                   cfg_frames_per_multiframe_m1);

    // the sync pin gates transmission; counters step every cycle while tx_go is high
    always @(posedge clk) begin
        if (!resetn) begin
            tx_seen_reg  <= 1'b0;
            tx_fpos_reg  <= `LFMDP_POS_RST;
            tx_kpos_reg  <= `LFMDP_KPOS_RST;
            tx_sof_reg   <= `LFMDP_MARK_RST;
            tx_som_reg   <= `LFMDP_MARK_RST;
            tx_live_reg  <= 1'b0;
            tx_ready_reg <= 1'b0;
        end else begin
            if (sysref_rise) begin
                tx_seen_reg <= 1'b1;
            end
            // ready trails the markers so each marker leads its word
            tx_ready_reg <= tx_live_reg;
            if (tx_go) begin
                tx_live_reg <= 1'b1;
                tx_fpos_reg <= tx_walk[`LFMDP_WALK_F_LSB +: 8];
                tx_kpos_reg <= tx_walk[`LFMDP_WALK_K_LSB +: 5];
                tx_sof_reg  <= tx_walk[`LFMDP_WALK_SOF_LSB +: 4];
                tx_som_reg  <= tx_walk[`LFMDP_WALK_SOM_LSB +: 4];
            end else begin
                // far end asks for resync: no words, no markers
                tx_live_reg <= 1'b0;
                tx_fpos_reg <= `LFMDP_POS_RST;
                tx_kpos_reg <= `LFMDP_KPOS_RST;
                tx_sof_reg  <= `LFMDP_MARK_RST;
                tx_som_reg  <= `LFMDP_MARK_RST;
            end
        end
    end

    assign tx_tready                  = tx_ready_reg;
    assign tx_frame_begin_marker      = tx_sof_reg;
    assign tx_multiframe_begin_marker = tx_som_reg;

    // receive framing
    reg [7:0] rx_fpos_reg;     // octet within frame of next lane word
    reg       rst_out_reg;     // stream reset, low during reset
    reg       rx_sync_reg;     // sync request towards far end

    wire          buf_in_ready;
    wire          buf_out_valid;
    wire [BW-1:0] buf_out_data;
    wire          pipe_adv;
    wire          rx_take = lane_valid & lane_aligned & buf_in_ready;
    wire [`LFMDP_WALK_BITS-1:0] rx_walk =
        lfmdp_walk(rx_fpos_reg, `LFMDP_KPOS_RST,
                   cfg_octets_per_frame_m1, 5'h00);

    // counters stay at zero until alignment, so the first word
    // after alignment starts a frame in byte 0
    always @(posedge clk) begin
        if (!resetn) begin
            rx_fpos_reg <= `LFMDP_POS_RST;
            rst_out_reg <= 1'b0;
            rx_sync_reg <= 1'b0;
        end else begin
            rst_out_reg <= 1'b1;
            rx_sync_reg <= lane_aligned;
            if (!lane_aligned) begin
                rx_fpos_reg <= `LFMDP_POS_RST;
            end else if (rx_take) begin
                rx_fpos_reg <= rx_walk[`LFMDP_WALK_F_LSB +: 8];
            end
        end
    end

    // markers travel with their word so a stall cannot split them;
    // lane words pass unchanged: lane N in slice N, first octet low
    lfmdp_buf2 #(
        .W (BW)
    ) u_buf (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (lane_valid & lane_aligned),
        .in_ready  (buf_in_ready),
        .in_data   ({rx_walk[`LFMDP_WALK_EOF_LSB +: 4],
                     rx_walk[`LFMDP_WALK_SOF_LSB +: 4],
                     lane_data}),
        .out_valid (buf_out_valid),
        .out_ready (pipe_adv),
        .out_data  (buf_out_data)
    );

    // receive output pipeline
    reg          a_valid_reg;  // word whose markers are on the pins
    reg [DW-1:0] a_data_reg;   // that word's data
    reg [3:0]    rx_sof_reg;   // frame begin marker for word a
    reg [3:0]    rx_eof_reg;   // frame finish marker for word a
    reg          b_valid_reg;  // word on rx_tdata
    reg [DW-1:0] b_data_reg;   // rx_tdata itself

    // the whole pipe moves when the output is empty or taken
    assign pipe_adv = ~b_valid_reg | rx_tready;

    // stage a shows markers one cycle before stage b shows the data
    always @(posedge clk) begin
        if (!resetn) begin
            a_valid_reg <= 1'b0;
            a_data_reg  <= {DW{1'b0}};
            rx_sof_reg  <= `LFMDP_MARK_RST;
            rx_eof_reg  <= `LFMDP_MARK_RST;
            b_valid_reg <= 1'b0;
            b_data_reg  <= {DW{1'b0}};
        end else if (pipe_adv) begin
            b_valid_reg <= a_valid_reg;
            b_data_reg  <= a_data_reg;
            a_valid_reg <= buf_out_valid;
            a_data_reg  <= buf_out_data[DW-1:0];
            if (buf_out_valid) begin
                rx_sof_reg <= buf_out_data[DW +: 4];
                rx_eof_reg <= buf_out_data[DW+4 +: 4];
            end else begin
                rx_sof_reg <= `LFMDP_MARK_RST;
                rx_eof_reg <= `LFMDP_MARK_RST;
            end
        end
    end

    // every receive output comes from a flop on clk
    assign lane_ready             = buf_in_ready;
    assign rx_aresetn             = rst_out_reg;
    assign rx_tdata               = b_data_reg;
    assign rx_tvalid              = b_valid_reg;
    assign rx_frame_begin_marker  = rx_sof_reg;
    assign rx_frame_finish_marker = rx_eof_reg;
    assign rx_sync_n              = rx_sync_reg;
endmodule // lfmdp_top

// ### tb/lfmdp_sink.sv
// stream consumer standing in for the user transport logic
// assumes the core clock and the synchronous active-low reset
module lfmdp_sink (
    input  logic clk,
    input  logic resetn,
    input  logic slow,
    output logic rx_tready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase_reg;  // stall phase counter
    // free-running phase, cleared in reset
    always @(posedge clk) begin
        phase_reg <= resetn ? phase_reg + 2'h1 : 2'h0;
    end
    // slow: ready one cycle in four, so the core buffer fills up
    assign rx_tready = !slow || phase_reg == 2'h3;
endmodule // lfmdp_sink

// ### tb/lfmdp_top_sva.sv
// concurrent checks on the marker data port pins
// assumes one core clock and a synchronous active-low reset
module lfmdp_chk #(
    parameter LANES = 4
) (
    input logic                clk,
    input logic                resetn,
    input logic [1:0]          cfg_subclass,
    input logic [7:0]          cfg_octets_per_frame_m1,
    input logic [4:0]          cfg_frames_per_multiframe_m1,
    input logic                sysref,
    input logic                tx_sync_n,
    input logic                tx_tready,
    input logic [3:0]          tx_frame_begin_marker,
    input logic [3:0]          tx_multiframe_begin_marker,
    input logic [32*LANES-1:0] lane_data,
    input logic                lane_valid,
    input logic                lane_aligned,
    input logic                lane_ready,
    input logic                rx_aresetn,
    input logic [32*LANES-1:0] rx_tdata,
    input logic                rx_tvalid,
    input logic                rx_tready,
    input logic [3:0]          rx_frame_begin_marker,
    input logic [3:0]          rx_frame_finish_marker,
    input logic                rx_sync_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // a single low sample of sync clears markers, then ready
    a_tx_refused: assert property (!tx_sync_n |-> ##3
        (tx_frame_begin_marker == 4'h0) ##1 !tx_tready)
        else $error("tx refusal late");
    a_tx_first_word: assert property ($rose(tx_tready) |->
        $past(tx_frame_begin_marker[0]) &&
        $past(tx_multiframe_begin_marker[0]))
        else $error("tx first word");
    a_tx_four_octets: assert property (
        cfg_octets_per_frame_m1 == 8'h03 &&
        cfg_frames_per_multiframe_m1 == 5'h00 &&
        tx_frame_begin_marker != 4'h0 |->
        tx_frame_begin_marker == 4'h1 &&
        tx_multiframe_begin_marker == 4'h1)
        else $error("tx F4 code");
    a_tx_one_octet: assert property (
        cfg_octets_per_frame_m1 == 8'h00 &&
        tx_frame_begin_marker != 4'h0 |-> tx_frame_begin_marker == 4'hF)
        else $error("tx F1 code");
    a_rx_one_octet: assert property (
        cfg_octets_per_frame_m1 == 8'h00 &&
        rx_frame_begin_marker != 4'h0 |-> rx_frame_finish_marker == 4'hF)
        else $error("rx F1 code");
    a_rx_two_octets: assert property (
        cfg_octets_per_frame_m1 == 8'h01 &&
        rx_frame_begin_marker != 4'h0 |->
        rx_frame_begin_marker == 4'h5 && rx_frame_finish_marker == 4'hA)
        else $error("rx F2 code");
    a_rx_stall_hold: assert property (
        rx_tvalid && !rx_tready |=> rx_tvalid && $stable(rx_tdata) &&
        $stable(rx_frame_begin_marker))
        else $error("rx stall lost");
    a_rx_sync_lag: assert property ($past(resetn) |->
        rx_sync_n == $past(lane_aligned))
        else $error("rx sync lag");
    a_rx_reset_out: assert property (!$past(resetn) |->
        lane_ready && !rx_tvalid ##1 rx_aresetn)
        else $error("rx reset outputs");
    a_rx_answer: assert property (
        lane_valid && lane_aligned && lane_ready && !rx_tvalid &&
        rx_tready |-> ##[1:3] rx_tvalid)
        else $error("rx valid late");
endmodule // lfmdp_chk
bind lfmdp_top lfmdp_chk #(.LANES(LANES)) u_lfmdp_chk (.*);

// ### tb/test_lane_frame_marker_data_port.sv
// self-checking bench for the marker data port
// assumes lfmdp_top, the sink model and the bound checker
module test_lane_frame_marker_data_port;
    timeunit 1ns;
    timeprecision 1ns;
    localparam L = 4;
    typedef struct packed {logic [7:0] f; logic [3:0] b0, f0, b1, f1;}
        lfmdp_row_t;
    logic clk = 0, resetn = 0, sysref = 0, tx_sync_n = 0, slow = 0, full;
    logic lane_valid = 0, lane_aligned = 0, took = 0;
    logic [1:0] cfg_subclass = 2'h0;
    logic [7:0] cfg_octets_per_frame_m1 = 8'h00;
    logic [4:0] cfg_frames_per_multiframe_m1 = 5'h00;
    logic [3:0] pb, pf;  // markers one cycle before valid
    wire [3:0] tx_frame_begin_marker, tx_multiframe_begin_marker;
    wire [3:0] rx_frame_begin_marker, rx_frame_finish_marker;
    wire tx_tready, lane_ready, rx_aresetn, rx_tvalid, rx_tready, rx_sync_n;
    wire [32*L-1:0] rx_tdata, lane_data;
    int word_idx = 0, rx_idx = 0, fail_count = 0, total_checks = 0, cyc = 0;
    // ordinary cases: frame size against first two words' markers
    lfmdp_row_t rows [5] = '{'{8'h00, 4'hF, 4'hF, 4'hF, 4'hF},
        '{8'h01, 4'h5, 4'hA, 4'h5, 4'hA}, '{8'h02, 4'h9, 4'h4, 4'h4, 4'h2},
        '{8'h03, 4'h1, 4'h8, 4'h1, 4'h8}, '{8'h07, 4'h1, 4'h0, 4'h0, 4'h8}};
    lfmdp_top #(.LANES(L)) u_lfmdp_top (.*);
    lfmdp_sink u_lfmdp_sink (.*);
    always #25 clk = ~clk;
    // lane n of word i: lane number on top, word index below
    function automatic logic [32*L-1:0] mk(int i);
        for (int n = 0; n < L; n++) mk[n*32+:32] = {8'(n), 24'(i)};
    endfunction
    assign lane_data = mk(word_idx);
    task chk_data(string n, logic [32*L-1:0] e, logic [32*L-1:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_mark(string n, logic [3:0] e, logic [3:0] g);
        chk_data(n, {{(32*L-4){1'b0}}, e}, {{(32*L-4){1'b0}}, g});
    endtask
    task chk_bit(string n, logic e, logic g);
        chk_data(n, {{(32*L-1){1'b0}}, e}, {{(32*L-1){1'b0}}, g});
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            results;
        end
    end
    // lane source bookkeeping and in-order scoreboard on the stream
    always @(posedge clk) begin
        took <= resetn && lane_valid && lane_aligned && lane_ready;
        if (!resetn) rx_idx <= 0;
        else if (rx_tvalid === 1'b1 && rx_tready === 1'b1) begin
            chk_data("rx_tdata", mk(rx_idx), rx_tdata);
            rx_idx <= rx_idx + 1;
        end
    end
    // next lane word only once the last one was taken
    always @(negedge clk) word_idx = !resetn ? 0 : word_idx + int'(took);
    task rst(logic [7:0] f, logic [4:0] k, logic [1:0] s);
        @(negedge clk);
        resetn = 0;
        cfg_octets_per_frame_m1 = f;
        cfg_frames_per_multiframe_m1 = k;
        cfg_subclass = s;
        {tx_sync_n, sysref, lane_valid, lane_aligned, slow} = 5'h00;
        repeat (4) @(negedge clk);
        chk_bit("rx_aresetn", 1'b0, rx_aresetn);
        chk_bit("rx_tvalid", 1'b0, rx_tvalid);
        resetn = 1;
    endtask
    // bounded wait for a valid level, keeping the markers before it
    task wv(logic w);
        for (int n = 0; n < 20 && rx_tvalid !== w; n++) begin
            pb = rx_frame_begin_marker;
            pf = rx_frame_finish_marker;
            @(negedge clk);
        end
        chk_bit("rx_tvalid", w, rx_tvalid);
    endtask
    initial begin
        foreach (rows[i]) begin
            rst(rows[i].f, 5'h00, 2'h0);
            {lane_aligned, lane_valid} = 2'h3;
            wv(1'b1);
            chk_mark("begin0", rows[i].b0, pb);
            chk_mark("finish0", rows[i].f0, pf);
            chk_mark("begin1", rows[i].b1, rx_frame_begin_marker);
            chk_mark("finish1", rows[i].f1, rx_frame_finish_marker);
        end
        // slow consumer: buffer must refuse, then drain without loss
        rst(8'h01, 5'h00, 2'h0);
        {slow, lane_aligned, lane_valid, full} = 4'hE;
        repeat (40) begin
            @(negedge clk);
            if (lane_ready === 1'b0) full = 1;
        end
        {lane_valid, slow} = 2'h0;
        wv(1'b0);
        chk_bit("lane_ready_low", 1'b1, full);
        chk_bit("drained", 1'b1, word_idx == rx_idx);
        // words before alignment are ignored, then framing restarts
        {lane_aligned, lane_valid} = 2'h1;
        repeat (6) @(negedge clk);
        chk_bit("unaligned", 1'b0, rx_tvalid);
        chk_bit("rx_sync_n", 1'b0, rx_sync_n);
        lane_aligned = 1;
        wv(1'b1);
        chk_mark("realign", 4'h5, pb);
        chk_bit("rx_sync_n", 1'b1, rx_sync_n);
        lane_valid = 0;
        // transmit, four octets per frame, one frame per multiframe
        rst(8'h03, 5'h00, 2'h0);
        tx_sync_n = 1;
        repeat (3) @(negedge clk);
        chk_mark("tx_mf", 4'h1, tx_multiframe_begin_marker);
        chk_bit("tx_tready", 1'b0, tx_tready);
        @(negedge clk);
        chk_bit("tx_tready", 1'b1, tx_tready);
        // one octet per frame, four frames per multiframe
        rst(8'h00, 5'h03, 2'h0);
        tx_sync_n = 1;
        repeat (6) @(negedge clk);
        chk_mark("tx_f1", 4'hF, tx_frame_begin_marker);
        chk_mark("tx_mf_k4", 4'h1, tx_multiframe_begin_marker);
        tx_sync_n = 0;
        repeat (4) @(negedge clk);
        chk_mark("tx_off", 4'h0, tx_frame_begin_marker);
        @(negedge clk);
        chk_bit("tx_tready", 1'b0, tx_tready);
        // subclass 1 waits for the system reference
        rst(8'h03, 5'h00, 2'h1);
        tx_sync_n = 1;
        repeat (8) @(negedge clk);
        chk_bit("tx_no_ref", 1'b0, tx_tready);
        sysref = 1;
        @(negedge clk);
        sysref = 0;
        repeat (6) @(negedge clk);
        chk_bit("tx_ref", 1'b1, tx_tready);
        chk_mark("tx_ref_sof", 4'h1, tx_frame_begin_marker);
        results;
    end
endmodule // test_lane_frame_marker_data_port
